// ===== rtl/tx_ctrl_defs.vh
`ifndef TX_CTRL_DEFS_VH
`define TX_CTRL_DEFS_VH

// ****************************************
// Serial word layout
// ****************************************
`define WORD_BITS 24
`define ADDR_BITS 4
`define DATA_BITS 20

// ****************************************
// Register addresses
// ****************************************
`define ADDR_RF_MAIN 4'h0
`define ADDR_RF_REF 4'h1
`define ADDR_IF_MAIN 4'h2
`define ADDR_IF_REF 4'h3
`define ADDR_OPERATION_CONTROL 4'h4
`define ADDR_CONFIG 4'h5
`define ADDR_TEST 4'h7

// ****************************************
// Meaningful widths
// ****************************************
`define W_RF_MAIN 18
`define W_RF_REF 13
`define W_IF_MAIN 14
`define W_IF_REF 11
`define W_CTRL 16
`define W_TEST 8

// ****************************************
// Power-up values
// ****************************************
`define RST_RF_MAIN 18'h2a037
`define RST_RF_REF 13'h07b0
`define RST_IF_MAIN 14'h1977
`define RST_IF_REF 11'h1ec
`define RST_OPERATION_CONTROL 16'h892f
`define RST_CONFIG 16'hd03f
`define RST_TEST 8'h00

// ****************************************
// Operation control fields
// ****************************************
`define OP_SOFT_OFF 0
`define OP_TX_STANDBY_BIT 1
`define OP_STANDBY_BIT 2
`define OP_IF_HOLD 13
`define OP_RF_HOLD 14

// ****************************************
// Configuration fields
// ****************************************
`define CF_RF_FAST 4
`define CF_IF_FAST 5
`define CF_RF_PUMP_LSB 0
`define CF_IF_PUMP_LSB 2
`define PUMP_W 2
`define PUMP_MAX 2'h3

`endif

// ===== rtl/pin_sync.v
`default_nettype none

// Two-stage synchroniser, reset to a given level
module pin_sync #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Asynchronous in, synchronous out
   input wire d,
   output wire q
);
   reg s1_q;
   reg s2_q;

   // First stage feeds only the second
   always @(posedge clk) begin
      if (rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end

   assign q = s2_q;
endmodule // pin_sync

`default_nettype wire

// ===== rtl/fast_acquire.v
`default_nettype none

`include "tx_ctrl_defs.vh"

// Turbo charge-pump control for one loop
module fast_acquire (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Setup
   input wire enable,
   input wire hold_high,
   input wire [`PUMP_W-1:0] pump_setting,
   // Loop status, synchronous
   input wire acquire_start,
   input wire phase_lead,
   input wire freq_acquired,
   // Result
   output reg turbo_q,
   output reg [`PUMP_W-1:0] pump_current_q
);
   reg lead_q;
   reg [1:0] flips_q;
   wire flip = (phase_lead != lead_q);
   wire done = (flips_q == 2'd1 && flip) || freq_acquired;
   wire turbo_d = enable & ((acquire_start | turbo_q) & ~done | (hold_high & turbo_q));

   // Count lead/lag swaps since acquisition began
   always @(posedge clk) begin
      if (rst) begin
         lead_q <= 1'b0;
         flips_q <= 2'd0;
         turbo_q <= 1'b0;
         pump_current_q <= `PUMP_MAX;
      end else begin
         lead_q <= phase_lead;
         if (acquire_start)
            flips_q <= 2'd0;
         else if (flip && flips_q != 2'd2)
            flips_q <= flips_q + 2'd1;
         turbo_q <= turbo_d; // RL1 RL2 RL3 RL22
         // Max current in turbo, else programmed level
         pump_current_q <= turbo_d ? `PUMP_MAX : pump_setting; // RL1 RL4
      end
   end
endmodule // fast_acquire

`default_nettype wire

// ===== rtl/tx_serial_regs.v
`default_nettype none

`include "tx_ctrl_defs.vh"

// Operation
// RL1: Turbo bit set drives pump at maximum current while loop acquires.
// RL2: Turbo ends after second lead/lag phase swap.
// RL3: Turbo also ends on frequency acquisition, whichever first.
// RL4: After turbo, pump current returns to configured setting.
// RL5: Words are 24 bits; 24-bit shift register held.
// RL6: Low 4 bits address, upper 20 bits data.
// RL7: Unused data bits have no effect.
// RL8: Host sends MSB first, address last.
// RL9: Data sampled on each rising serial clock while select low.
// RL10: Select rising copies data into addressed register.
// RL11: Divider power-up counts 172087, 1968, 6519, 492.
// RL12: Control 892F, configuration D03F, test 0000 at power-up.
// RL13: Address codes 0-3 dividers, 4 control, 5 config, 7 test.
// RL14: RF loop divides VCO by main, reference by reference count.
// RL15: IF loop uses IF main and reference counts alike.
// RL16: Soft off bit keeps serial port alive, rest powered down.
// RL17: Hard power-off pin powers down everything including serial port.
// RL18: Either shutdown returns registers to power-up defaults.
// RL19: Standby powers down but keeps register contents.
// RL20: Soft off is control bit 0; zero resets registers.
// RL21: Standby is control bit 2; zero powers all but registers, port.
// RL22: Hold-current bits 14, 13 keep turbo on only with turbo enabled.
// RL23: Transmit standby bit 1 zero disables modulator, upconverter only.
// RL24: Widths 18, 13, 14, 11, 16, 16, 8 bits.
// RL25: Serial clock with select high changes nothing.
// RL26: Undefined address changes no register.
module tx_serial_regs (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Three-wire serial port and hard power-off pin, asynchronous pins
   input wire sclk,
   input wire sdata,
   input wire cs_n,
   input wire hard_power_off_pin_n,
   // RF loop status from the analog loop
   input wire rf_acquire_start,
   input wire rf_phase_lead,
   input wire rf_freq_acquired,
   input wire rf_vco_edge,
   input wire rf_ref_edge,
   // IF loop status
   input wire if_acquire_start,
   input wire if_phase_lead,
   input wire if_freq_acquired,
   input wire if_vco_edge,
   input wire if_ref_edge,
   // Programmed contents
   output reg [`W_RF_MAIN-1:0] rf_main_divider_q,
   output reg [`W_RF_REF-1:0] rf_reference_divider_q,
   output reg [`W_IF_MAIN-1:0] if_main_divider_q,
   output reg [`W_IF_REF-1:0] if_reference_divider_q,
   output reg [`W_CTRL-1:0] operation_control_q,
   output reg [`W_CTRL-1:0] loop_and_input_setup_q,
   output reg [`W_TEST-1:0] test_mode_control_q,
   // Power states
   output reg serial_port_on_q,
   output reg core_on_q,
   output reg transmit_on_q,
   // Loop divider outputs
   output reg rf_main_pulse_q,
   output reg rf_ref_pulse_q,
   output reg if_main_pulse_q,
   output reg if_ref_pulse_q,
   // Charge pumps
   output wire rf_turbo_q,
   output wire [`PUMP_W-1:0] rf_pump_current_q,
   output wire if_turbo_q,
   output wire [`PUMP_W-1:0] if_pump_current_q
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire sclk_s;
   wire sdata_s;
   wire cs_n_s;
   wire hard_off_n_s;
   wire rf_vco_s;
   wire rf_ref_s;
   wire if_vco_s;
   wire if_ref_s;

   // Serial clock, parked low between frames
   pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (
      .clk(clk),
      .rst(rst),
      .d(sclk),
      .q(sclk_s)
   );

   // Serial data, same delay as the clock
   pin_sync #(.RST_VAL(1'b0)) u_sync_sdata (
      .clk(clk),
      .rst(rst),
      .d(sdata),
      .q(sdata_s)
   );

   // Select resets high, so no latch follows reset
   pin_sync #(.RST_VAL(1'b1)) u_sync_cs (
      .clk(clk),
      .rst(rst),
      .d(cs_n),
      .q(cs_n_s)
   );

   // Hard power-off pin, resets inactive
   pin_sync #(.RST_VAL(1'b1)) u_sync_off (
      .clk(clk),
      .rst(rst),
      .d(hard_power_off_pin_n),
      .q(hard_off_n_s)
   );

   // RF main loop clock
   pin_sync #(.RST_VAL(1'b0)) u_sync_rfv (
      .clk(clk),
      .rst(rst),
      .d(rf_vco_edge),
      .q(rf_vco_s)
   );

   // RF reference clock
   pin_sync #(.RST_VAL(1'b0)) u_sync_rfr (
      .clk(clk),
      .rst(rst),
      .d(rf_ref_edge),
      .q(rf_ref_s)
   );

   // IF main loop clock
   pin_sync #(.RST_VAL(1'b0)) u_sync_ifv (
      .clk(clk),
      .rst(rst),
      .d(if_vco_edge),
      .q(if_vco_s)
   );

   // IF reference clock
   pin_sync #(.RST_VAL(1'b0)) u_sync_ifr (
      .clk(clk),
      .rst(rst),
      .d(if_ref_edge),
      .q(if_ref_s)
   );

   // ****************************************
   // Edge detection
   // ****************************************
   reg sclk_d_q;
   reg cs_n_d_q;
   reg [3:0] loop_d_q;
   wire sclk_rise = sclk_s & ~sclk_d_q;
   wire cs_rise = cs_n_s & ~cs_n_d_q;
   wire [3:0] loop_now = {if_ref_s, if_vco_s, rf_ref_s, rf_vco_s};
   wire [3:0] loop_rise = loop_now & ~loop_d_q;

   // Delayed copies, read only after the second sync stage
   // Reset values match idle pin levels, so no false edge follows reset
   always @(posedge clk) begin
      if (rst) begin
         sclk_d_q <= 1'b0;
         cs_n_d_q <= 1'b1;
         loop_d_q <= 4'h0;
      end else begin
         sclk_d_q <= sclk_s;
         cs_n_d_q <= cs_n_s;
         loop_d_q <= loop_now;
      end
   end

   // ****************************************
   // Control and setup fields
   // ****************************************
   // Only these positions are decoded; the other bits cannot act
   wire soft_power_off_bit = operation_control_q[`OP_SOFT_OFF]; // RL20
   wire transmit_standby_bit = operation_control_q[`OP_TX_STANDBY_BIT]; // RL23
   wire standby_bit = operation_control_q[`OP_STANDBY_BIT]; // RL21
   wire rf_hold_high_current = operation_control_q[`OP_RF_HOLD]; // RL22
   wire if_hold_high_current = operation_control_q[`OP_IF_HOLD]; // RL22
   wire rf_fast_acquire_enable = loop_and_input_setup_q[`CF_RF_FAST]; // RL1
   wire if_fast_acquire_enable = loop_and_input_setup_q[`CF_IF_FAST]; // RL1
   wire [`PUMP_W-1:0] rf_pump_current_setting =
      loop_and_input_setup_q[`CF_RF_PUMP_LSB+`PUMP_W-1:`CF_RF_PUMP_LSB]; // RL4
   wire [`PUMP_W-1:0] if_pump_current_setting =
      loop_and_input_setup_q[`CF_IF_PUMP_LSB+`PUMP_W-1:`CF_IF_PUMP_LSB]; // RL4

   // ****************************************
   // Shift register and power-off
   // ****************************************
   reg [`WORD_BITS-1:0] shift_q;
   wire hard_off = ~hard_off_n_s;
   wire soft_off = ~soft_power_off_bit;
   // Hard off also drops the serial port; soft off keeps it
   wire port_live = ~hard_off; // RL16 RL17

   // Shift MSB first on rising serial clock while selected
   // Sync costs two cycles, so the serial clock must stay well below clk
   always @(posedge clk) begin
      if (rst || hard_off) begin
         shift_q <= {`WORD_BITS{1'b0}};
      end else if (port_live && !cs_n_s && sclk_rise) begin
         shift_q <= {shift_q[`WORD_BITS-2:0], sdata_s}; // RL5 RL8 RL9 RL25
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   wire [`ADDR_BITS-1:0] addr = shift_q[`ADDR_BITS-1:0]; // RL6
   wire [`DATA_BITS-1:0] data = shift_q[`WORD_BITS-1:`ADDR_BITS]; // RL6
   wire load = port_live && cs_rise; // RL10
   // A latched control word with bit 0 clear resets every register in the file, itself included
   wire soft_reset = soft_off; // RL18 RL20

   // Only the meaningful low bits are kept; the rest cannot act
   // Power-off clears win over a load in the same cycle
   // Test word is stored only; no logic here acts on it
   always @(posedge clk) begin
      if (rst || hard_off || soft_reset) begin
         rf_main_divider_q <= `RST_RF_MAIN; // RL11 RL18
         rf_reference_divider_q <= `RST_RF_REF;
         if_main_divider_q <= `RST_IF_MAIN;
         if_reference_divider_q <= `RST_IF_REF;
         operation_control_q <= `RST_OPERATION_CONTROL; // RL12
         loop_and_input_setup_q <= `RST_CONFIG;
         test_mode_control_q <= `RST_TEST;
      end else if (load) begin
         case (addr) // RL13 RL26
            `ADDR_RF_MAIN: rf_main_divider_q <= data[`W_RF_MAIN-1:0]; // RL7 RL24
            `ADDR_RF_REF: rf_reference_divider_q <= data[`W_RF_REF-1:0];
            `ADDR_IF_MAIN: if_main_divider_q <= data[`W_IF_MAIN-1:0];
            `ADDR_IF_REF: if_reference_divider_q <= data[`W_IF_REF-1:0];
            `ADDR_OPERATION_CONTROL: operation_control_q <= data[`W_CTRL-1:0];
            `ADDR_CONFIG: loop_and_input_setup_q <= data[`W_CTRL-1:0];
            `ADDR_TEST: test_mode_control_q <= data[`W_TEST-1:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Power states
   // ****************************************
   // Standby keeps registers; soft off held one cycle before reset clears it
   // Soft off leaves the port alive so the host can wake the part
   always @(posedge clk) begin
      if (rst) begin
         serial_port_on_q <= 1'b1;
         core_on_q <= 1'b1;
         transmit_on_q <= 1'b1;
      end else begin
         serial_port_on_q <= port_live; // RL16 RL17
         core_on_q <= port_live & ~soft_off & standby_bit; // RL19 RL21
         transmit_on_q <= port_live & ~soft_off & standby_bit
            & transmit_standby_bit; // RL23
      end
   end

   // ****************************************
   // Loop dividers
   // ****************************************
   reg [`W_RF_MAIN-1:0] cnt_q [0:3];
   wire [`W_RF_MAIN-1:0] lim [0:3];
   wire [3:0] wrap;
   assign lim[0] = rf_main_divider_q;
   assign lim[1] = {{(`W_RF_MAIN-`W_RF_REF){1'b0}}, rf_reference_divider_q};
   assign lim[2] = {{(`W_RF_MAIN-`W_IF_MAIN){1'b0}}, if_main_divider_q};
   assign lim[3] = {{(`W_RF_MAIN-`W_IF_REF){1'b0}}, if_reference_divider_q};

   // One pulse every count input edges; zero count treated as one
   // Counts clear while the core sleeps, so waking starts a fresh period
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_div
         assign wrap[gi] = loop_rise[gi] && (cnt_q[gi] + 18'd1 >= lim[gi]);
         always @(posedge clk) begin
            if (rst || !core_on_q)
               cnt_q[gi] <= {`W_RF_MAIN{1'b0}};
            else if (wrap[gi])
               cnt_q[gi] <= {`W_RF_MAIN{1'b0}};
            else if (loop_rise[gi])
               cnt_q[gi] <= cnt_q[gi] + 18'd1;
         end
      end
   endgenerate

   // Registered divider outputs feed the phase detectors
   // One cycle wide; the detector needs only the edge
   always @(posedge clk) begin
      if (rst) begin
         rf_main_pulse_q <= 1'b0;
         rf_ref_pulse_q <= 1'b0;
         if_main_pulse_q <= 1'b0;
         if_ref_pulse_q <= 1'b0;
      end else begin
         rf_main_pulse_q <= wrap[0]; // RL14
         rf_ref_pulse_q <= wrap[1]; // RL14
         if_main_pulse_q <= wrap[2]; // RL15
         if_ref_pulse_q <= wrap[3]; // RL15
      end
   end

   // ****************************************
   // Turbo acquisition
   // ****************************************
   // Turbo only while the core is awake
   wire rf_turbo_allowed = rf_fast_acquire_enable & core_on_q; // RL1
   wire if_turbo_allowed = if_fast_acquire_enable & core_on_q; // RL1

   // RF loop
   fast_acquire u_rf_fast (
      .clk(clk),
      .rst(rst),
      .enable(rf_turbo_allowed), // RL1
      .hold_high(rf_hold_high_current), // RL22
      .pump_setting(rf_pump_current_setting), // RL4
      .acquire_start(rf_acquire_start),
      .phase_lead(rf_phase_lead),
      .freq_acquired(rf_freq_acquired),
      .turbo_q(rf_turbo_q),
      .pump_current_q(rf_pump_current_q)
   );

   // IF loop
   fast_acquire u_if_fast (
      .clk(clk),
      .rst(rst),
      .enable(if_turbo_allowed), // RL1
      .hold_high(if_hold_high_current), // RL22
      .pump_setting(if_pump_current_setting), // RL4
      .acquire_start(if_acquire_start),
      .phase_lead(if_phase_lead),
      .freq_acquired(if_freq_acquired),
      .turbo_q(if_turbo_q),
      .pump_current_q(if_pump_current_q)
   );
endmodule // tx_serial_regs

`default_nettype wire

// ===== verif/serial_host_model.sv
`default_nettype none

// ****************************************
// Host side of the three-wire port
// ****************************************
module serial_host_model (
   // Serial pins
   output logic sclk,
   output logic sdata,
   output logic cs_n
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam real HALF = 62.5;

   // Clock parked low and select idle between frames
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      cs_n = 1'b1;
   end

   // One whole word, top bit first, address last
   task automatic send(input logic [23:0] w);
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdata = w[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      #HALF cs_n = 1'b1;
      sdata = ~sdata; // Released line must not look like the last bit
   endtask

   // Clock pulses with select high
   task automatic stray(input int n);
      repeat (n) begin
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
   endtask
endmodule // serial_host_model

`default_nettype wire

// ===== verif/tx_serial_regs_chk.sv
`default_nettype none
`include "tx_ctrl_defs.vh"

// ****************************************
// Port checker
// ****************************************
module tx_serial_regs_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins and loop status
   input wire logic cs_n,
   input wire logic hard_power_off_pin_n,
   input wire logic rf_acquire_start,
   input wire logic rf_freq_acquired,
   // Outputs watched
   input wire logic [`W_RF_MAIN-1:0] rf_main_divider_q,
   input wire logic [`W_CTRL-1:0] operation_control_q,
   input wire logic [`W_CTRL-1:0] loop_and_input_setup_q,
   input wire logic [`W_TEST-1:0] test_mode_control_q,
   input wire logic serial_port_on_q,
   input wire logic core_on_q,
   input wire logic rf_turbo_q,
   input wire logic [`PUMP_W-1:0] rf_pump_current_q
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] since_q;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Cycles since select went high, saturating so long idles stay legal
   always_ff @(posedge clk) begin
      if (rst || !cs_n) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
   end

   div_reset_a: assert property ($fell(rst) |-> rf_main_divider_q == `RST_RF_MAIN)
      else $error("divider not at power-up value");
   ctrl_reset_a: assert property ($fell(rst) |-> operation_control_q == `RST_OPERATION_CONTROL
      && loop_and_input_setup_q == `RST_CONFIG && test_mode_control_q == `RST_TEST)
      else $error("control words not at power-up value");
   turbo_start_a: assert property (rf_acquire_start && core_on_q && !rf_freq_acquired &&
      loop_and_input_setup_q[`CF_RF_FAST] |=> rf_turbo_q) else $error("turbo did not start");
   turbo_pump_a: assert property (rf_turbo_q && $past(rf_turbo_q) |->
      rf_pump_current_q == `PUMP_MAX) else $error("pump not at maximum in turbo");
   acq_end_a: assert property (rf_turbo_q && rf_freq_acquired && !rf_acquire_start &&
      !operation_control_q[`OP_RF_HOLD] |-> ##[1:2] !rf_turbo_q)
      else $error("turbo kept after acquisition");
   pump_back_a: assert property (!rf_turbo_q && !$past(rf_turbo_q) && !$past(rst) &&
      $stable(loop_and_input_setup_q) |->
      rf_pump_current_q == loop_and_input_setup_q[`CF_RF_PUMP_LSB +: `PUMP_W])
      else $error("pump not at configured setting");
   soft_off_a: assert property (!operation_control_q[`OP_SOFT_OFF] |=>
      operation_control_q == `RST_OPERATION_CONTROL && test_mode_control_q == `RST_TEST)
      else $error("soft off did not restore defaults");
   hard_off_a: assert property (!hard_power_off_pin_n [*5] |-> !serial_port_on_q &&
      rf_main_divider_q == `RST_RF_MAIN) else $error("hard off left port or registers");
   port_alive_a: assert property (hard_power_off_pin_n [*5] |-> serial_port_on_q)
      else $error("serial port off without hard off");
   load_time_a: assert property (($changed(test_mode_control_q) ||
      $changed(rf_main_divider_q)) && hard_power_off_pin_n && !$past(rst) |->
      since_q inside {[4'h2:4'h7]}) else $error("register changed outside a load");

   // Main scenarios reached
   cover property (rf_turbo_q && rf_freq_acquired);
   cover property (!operation_control_q[`OP_SOFT_OFF]);
   cover property (!hard_power_off_pin_n [*5]);
endmodule // tx_serial_regs_chk

bind tx_serial_regs tx_serial_regs_chk i_tx_serial_regs_chk (.clk(clk), .rst(rst),
   .cs_n(cs_n), .hard_power_off_pin_n(hard_power_off_pin_n),
   .rf_acquire_start(rf_acquire_start), .rf_freq_acquired(rf_freq_acquired),
   .rf_main_divider_q(rf_main_divider_q), .operation_control_q(operation_control_q),
   .loop_and_input_setup_q(loop_and_input_setup_q), .test_mode_control_q(test_mode_control_q),
   .serial_port_on_q(serial_port_on_q), .core_on_q(core_on_q), .rf_turbo_q(rf_turbo_q),
   .rf_pump_current_q(rf_pump_current_q));

`default_nettype wire

// ===== verif/tx_serial_regs_tb.sv
`default_nettype none
`include "tx_ctrl_defs.vh"

// ****************************************
// Testbench
// ****************************************
module tx_serial_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, sclk, sdata, cs_n, hard_n, acq, lead, fa, spo, core, txo, rft, ift;
   logic [3:0] ecnt = 4'h0;
   logic [3:0] pls;
   logic [17:0] rf_main_divider;
   logic [12:0] rf_reference_divider;
   logic [13:0] if_main_divider;
   logic [10:0] if_reference_divider;
   logic [15:0] opc, cfg;
   logic [7:0] tst;
   logic [1:0] rfp, ifp;
   int failures, n_checks;
   int gap;

   serial_host_model i_serial_host_model (.sclk(sclk), .sdata(sdata), .cs_n(cs_n));

   tx_serial_regs i_tx_serial_regs (.clk(clk), .rst(rst), .sclk(sclk), .sdata(sdata),
      .cs_n(cs_n), .hard_power_off_pin_n(hard_n),
      .rf_acquire_start(acq), .rf_phase_lead(lead), .rf_freq_acquired(fa),
      .rf_vco_edge(ecnt[1]), .rf_ref_edge(ecnt[2]),
      .if_acquire_start(acq), .if_phase_lead(lead), .if_freq_acquired(fa),
      .if_vco_edge(ecnt[2]), .if_ref_edge(ecnt[3]),
      .rf_main_divider_q(rf_main_divider), .rf_reference_divider_q(rf_reference_divider), .if_main_divider_q(if_main_divider),
      .if_reference_divider_q(if_reference_divider), .operation_control_q(opc),
      .loop_and_input_setup_q(cfg), .test_mode_control_q(tst),
      .serial_port_on_q(spo), .core_on_q(core), .transmit_on_q(txo),
      .rf_main_pulse_q(pls[0]), .rf_ref_pulse_q(pls[1]), .if_main_pulse_q(pls[2]),
      .if_ref_pulse_q(pls[3]),
      .rf_turbo_q(rft), .rf_pump_current_q(rfp), .if_turbo_q(ift), .if_pump_current_q(ifp));

   // Clock and free-running loop edges
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(negedge clk) ecnt <= ecnt + 4'h1;

   // Compare and count
   task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Frame, then leave the load time to land
   task automatic wr(input logic [3:0] a, input logic [19:0] d);
      i_serial_host_model.send({d, a});
      repeat (8) @(negedge clk);
   endtask

   task automatic chk_def;
      check("rf_main", rf_main_divider, `RST_RF_MAIN);
      check("rf_ref", rf_reference_divider, `RST_RF_REF);
      check("if_main", if_main_divider, `RST_IF_MAIN);
      check("if_ref", if_reference_divider, `RST_IF_REF);
      check("operation_control", opc, `RST_OPERATION_CONTROL);
      check("setup", cfg, `RST_CONFIG);
      check("test", tst, `RST_TEST);
   endtask

   // Loop starts acquiring
   task automatic start_acq;
      acq = 1'b1;
      @(negedge clk);
      acq = 1'b0;
      @(negedge clk);
   endtask

   // Cycles between two pulses of one divider output, bounded
   task automatic per(input int k, output int n);
      int w;
      w = 0;
      while (!pls[k] && w < 300) begin
         @(negedge clk);
         w++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!pls[k] && n < 300);
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      hard_n = 1'b1;
      acq = 1'b0;
      lead = 1'b0;
      fa = 1'b0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      chk_def();
      // Distinct word per address, top 12 data bits set to fca
      for (int i = 0; i < 8; i++) if (i != 4 && i != 6) wr(i[3:0], {12'hfca, i[3:0], i[3:0]});
      check("rf_main", rf_main_divider, 20'h3ca00);
      check("rf_ref", rf_reference_divider, 20'h00a11);
      check("if_main", if_main_divider, 20'h00a22);
      check("if_ref", if_reference_divider, 20'h00233);
      check("setup", cfg, 20'h0ca55);
      check("test", tst, 20'h00077);
      // Undefined codes and stray clocks change nothing
      wr(4'h6, 20'h0);
      wr(4'h8, 20'h0);
      wr(4'hf, 20'h0);
      i_serial_host_model.stray(30);
      repeat (8) @(negedge clk);
      check("rf_main", rf_main_divider, 20'h3ca00);
      check("test", tst, 20'h00077);
      // Turbo ended by second phase swap
      wr(4'h5, 20'h00039);
      check("rf_pump", rfp, 20'h1);
      check("if_pump", ifp, 20'h2);
      start_acq();
      check("rf_turbo", rft, 20'h1);
      check("if_pump", ifp, `PUMP_MAX);
      lead = 1'b1;
      repeat (3) @(negedge clk);
      check("if_turbo", ift, 20'h1);
      lead = 1'b0;
      repeat (3) @(negedge clk);
      check("rf_turbo", rft, 20'h0);
      check("rf_pump", rfp, 20'h1);
      check("if_pump", ifp, 20'h2);
      // Ended by acquisition, unless hold bits set
      for (int h = 0; h < 2; h++) begin
         wr(4'h4, h ? 20'h0e92f : 20'h0892f);
         start_acq();
         fa = 1'b1;
         @(negedge clk);
         fa = 1'b0;
         repeat (3) @(negedge clk);
         check("rf_turbo", rft, h[19:0]);
         check("if_turbo", ift, h[19:0]);
      end
      wr(4'h5, 20'h00009);
      check("rf_turbo", rft, 20'h0);
      // Transmit standby, standby, then soft off
      wr(4'h4, 20'h0e92d);
      check("transmit_on", txo, 20'h0);
      check("core_on", core, 20'h1);
      wr(4'h4, 20'h0e92b);
      check("core_on", core, 20'h0);
      check("setup", cfg, 20'h00009);
      check("rf_main", rf_main_divider, 20'h3ca00);
      wr(4'h4, 20'h0e92e);
      chk_def();
      check("port_on", spo, 20'h1);
      // Hard off drops the port and the contents
      wr(4'h0, 20'h00005);
      hard_n = 1'b0;
      repeat (10) @(negedge clk);
      check("port_on", spo, 20'h0);
      check("rf_main", rf_main_divider, `RST_RF_MAIN);
      i_serial_host_model.send(24'h000070);
      repeat (8) @(negedge clk);
      check("rf_main", rf_main_divider, `RST_RF_MAIN);
      hard_n = 1'b1;
      repeat (8) @(negedge clk);
      wr(4'h0, 20'h00005);
      check("rf_main", rf_main_divider, 20'h00005);
      // Divider periods: loop clocks rise every 4, 8, 8 and 16 cycles
      wr(4'h1, 20'h00003);
      wr(4'h2, 20'h00002);
      wr(4'h3, 20'h00003);
      per(0, gap);
      check("rf_main_pulse", gap[19:0], 20'h14);
      per(1, gap);
      check("rf_ref_pulse", gap[19:0], 20'h18);
      per(2, gap);
      check("if_main_pulse", gap[19:0], 20'h10);
      per(3, gap);
      check("if_ref_pulse", gap[19:0], 20'h30);
      print_verdict();
   end
endmodule // tx_serial_regs_tb

`default_nettype wire
